/* File: shared/wwdt_defs.vh */
// constants for the window watchdog timer block
`ifndef WWDT_DEFS_VH
`define WWDT_DEFS_VH

// register offsets
`define WWDT_ADDR_CTRL     8'h00
`define WWDT_ADDR_STATUS   8'h01

// control register fields
`define WWDT_WIN_MSB       7
`define WWDT_WIN_LSB       4
`define WWDT_PER_MSB       3
`define WWDT_PER_LSB       0

// status register fields
`define WWDT_LOCK_BIT      7
`define WWDT_BUSY_BIT      0
`define WWDT_STATUS_RESET  8'h00

// timeout code range: code n selects 2^(n+2) watchdog clocks
`define WWDT_CODE_OFF      4'h0
`define WWDT_CODE_MAX      4'hb
`define WWDT_CODE_SHIFT    4'h2
`define WWDT_CNT_W         14

// watchdog ticks needed for a value to cross into the counter domain
`define WWDT_SYNC_TICKS    2'h2

// counter states
`define WWDT_ST_OFF        3'h0
`define WWDT_ST_NORMAL     3'h1
`define WWDT_ST_FIRST      3'h2
`define WWDT_ST_CLOSED     3'h3
`define WWDT_ST_OPEN       3'h4

`endif

/* File: logic/wwdt_top.v */
// window watchdog timer: registers, clock-domain crossing and timeout counter
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "wwdt_defs.vh"

module wwdt_top (
	input  wire       core_clk,                   // system clock, 20 MHz
	input  wire       reset,                      // synchronous reset, active high
	input  wire [7:0] reg_addr,                   // register address
	input  wire [7:0] reg_wdata,                  // register write data
	input  wire       reg_wr,                     // write strobe
	input  wire       reg_rd,                     // read strobe
	output reg  [7:0] reg_rdata_q,                // read data, cycle after strobe
	input  wire       watchdog_clear_instruction, // one-cycle clear from the core
	input  wire       timed_unlock_protection,    // unlock window with io key is open
	input  wire       cpu_debug_mode,             // core is under debug
	input  wire       cpu_halted,                 // core halted by debugger
	input  wire [7:0] watchdog_boot_fuse,         // fuse value for control at boot
	input  wire       watchdog_counter_clock,     // 1 kHz oscillator, asynchronous
	output reg        sys_reset_req_q             // reset request pulse
);

	// =====================================================================
	// helpers

	// length in watchdog clocks of a timeout code, zero for off or reserved
	function [`WWDT_CNT_W:0] code_len;
		input [3:0] code;
		begin
			if (code == `WWDT_CODE_OFF || code > `WWDT_CODE_MAX)
				code_len = {(`WWDT_CNT_W+1){1'b0}};
			else
				code_len = {{`WWDT_CNT_W{1'b0}}, 1'b1} << (code + `WWDT_CODE_SHIFT);
		end
	endfunction

	// =====================================================================
	// watchdog clock sampling and tick detection

	reg wclk_s1_q;
	reg wclk_s2_q;
	reg wclk_s3_q;
	wire tick = wclk_s2_q & ~wclk_s3_q;

	always @(posedge core_clk) begin
		wclk_s1_q <= watchdog_counter_clock;
		wclk_s2_q <= wclk_s1_q;
		wclk_s3_q <= wclk_s2_q;
	end

	// =====================================================================
	// register file, protection and boot load

	reg [7:0] ctrl_q;
	reg       lock_q;
	reg       boot_q;
	reg       busy_q;
	reg [1:0] busy_ticks_q;
	reg       clr_busy_q;
	reg [1:0] clr_ticks_q;
	reg [3:0] per_act_q;
	reg [3:0] win_act_q;
	reg       cfg_done_q;

	wire wr_ctrl   = reg_wr && reg_addr == `WWDT_ADDR_CTRL;
	wire wr_status = reg_wr && reg_addr == `WWDT_ADDR_STATUS;
	wire ctrl_ok   = wr_ctrl && timed_unlock_protection && !lock_q && !busy_q;
	wire fuse_on   = watchdog_boot_fuse[`WWDT_PER_MSB:`WWDT_PER_LSB] != `WWDT_CODE_OFF;

	always @(posedge core_clk) begin
		if (reset) begin
			ctrl_q <= 8'h00;
			lock_q <= 1'b0;
			boot_q <= 1'b1;
		end else if (boot_q) begin
			ctrl_q <= watchdog_boot_fuse;
			lock_q <= fuse_on;
			boot_q <= 1'b0;
		end else begin
			if (ctrl_ok)
				ctrl_q <= reg_wdata;
			if (wr_status && timed_unlock_protection) begin
				if (reg_wdata[`WWDT_LOCK_BIT])
					lock_q <= 1'b1;
				else if (cpu_debug_mode)
					lock_q <= 1'b0;
			end
		end
	end

	always @(posedge core_clk) begin
		if (reset) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd && reg_addr == `WWDT_ADDR_CTRL) begin
			reg_rdata_q <= ctrl_q;
		end else if (reg_rd && reg_addr == `WWDT_ADDR_STATUS) begin
			reg_rdata_q <= `WWDT_STATUS_RESET;
			reg_rdata_q[`WWDT_LOCK_BIT] <= lock_q;
			reg_rdata_q[`WWDT_BUSY_BIT] <= busy_q;
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	// =====================================================================
	// crossing of configuration and clears into the tick domain

	always @(posedge core_clk) begin
		if (reset) begin
			busy_q       <= 1'b0;
			busy_ticks_q <= 2'h0;
			per_act_q    <= 4'h0;
			win_act_q    <= 4'h0;
			cfg_done_q   <= 1'b0;
		end else begin
			cfg_done_q <= 1'b0;
			if (ctrl_ok || boot_q) begin
				busy_q       <= 1'b1;
				busy_ticks_q <= 2'h0;
			end else if (busy_q && tick) begin
				if (busy_ticks_q + 2'h1 == `WWDT_SYNC_TICKS) begin
					busy_q     <= 1'b0;
					per_act_q  <= ctrl_q[`WWDT_PER_MSB:`WWDT_PER_LSB];
					win_act_q  <= ctrl_q[`WWDT_WIN_MSB:`WWDT_WIN_LSB];
					cfg_done_q <= 1'b1;
				end
				busy_ticks_q <= busy_ticks_q + 2'h1;
			end
		end
	end

	wire clr_apply = clr_busy_q && tick && (clr_ticks_q + 2'h1 == `WWDT_SYNC_TICKS);

	always @(posedge core_clk) begin
		if (reset) begin
			clr_busy_q  <= 1'b0;
			clr_ticks_q <= 2'h0;
		end else if (!clr_busy_q) begin
			if (watchdog_clear_instruction) begin
				clr_busy_q  <= 1'b1;
				clr_ticks_q <= 2'h0;
			end
		end else if (tick) begin // clears during crossing are dropped
			clr_ticks_q <= clr_ticks_q + 2'h1;
			if (clr_apply)
				clr_busy_q <= 1'b0;
		end
	end

	// =====================================================================
	// timeout counter

	reg  [2:0]            state_q;
	reg  [2:0]            state_d;
	reg  [`WWDT_CNT_W:0]  cnt_q;
	reg  [`WWDT_CNT_W:0]  cnt_d;
	reg                   bite_d;
	reg                   halted_q;

	wire [`WWDT_CNT_W:0] open_len   = code_len(per_act_q);
	wire [`WWDT_CNT_W:0] closed_len = code_len(win_act_q);
	wire                 enabled    = open_len != {(`WWDT_CNT_W+1){1'b0}};
	wire                 win_mode   = win_act_q != `WWDT_CODE_OFF;
	wire [`WWDT_CNT_W:0] cnt_inc    = cnt_q + {{`WWDT_CNT_W{1'b0}}, 1'b1};
	wire [`WWDT_CNT_W:0] cnt_zero   = {(`WWDT_CNT_W+1){1'b0}};

	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q;
		bite_d  = 1'b0;
		if (!enabled) begin
			state_d = `WWDT_ST_OFF;
			cnt_d   = cnt_zero;
		end else if (cpu_halted) begin
			state_d = `WWDT_ST_OFF;
			cnt_d   = cnt_zero;
		end else begin
			case (state_q)
				`WWDT_ST_OFF: begin
					cnt_d   = cnt_zero;
					state_d = win_mode ? `WWDT_ST_FIRST : `WWDT_ST_NORMAL;
				end
				`WWDT_ST_NORMAL: begin
					if (cfg_done_q && win_mode) begin
						state_d = `WWDT_ST_FIRST;
						cnt_d   = cnt_zero;
					end else if (clr_apply) begin
						cnt_d = cnt_zero;
					end else if (tick) begin
						cnt_d = cnt_inc;
						if (cnt_inc >= open_len) begin
							bite_d = 1'b1;
							cnt_d  = cnt_zero;
						end
					end
				end
				`WWDT_ST_FIRST: begin
					if (!win_mode) begin
						state_d = `WWDT_ST_NORMAL;
					end else if (clr_apply) begin
						state_d = `WWDT_ST_CLOSED;
						cnt_d   = cnt_zero;
					end else if (tick) begin
						cnt_d = cnt_inc;
						if (cnt_inc >= open_len) begin
							bite_d = 1'b1;
							cnt_d  = cnt_zero;
						end
					end
				end
				`WWDT_ST_CLOSED: begin
					if (!win_mode) begin
						state_d = `WWDT_ST_NORMAL;
						cnt_d   = cnt_zero;
					end else if (clr_apply) begin
						bite_d = 1'b1;
						cnt_d  = cnt_zero;
					end else if (tick) begin
						cnt_d = cnt_inc;
						if (cnt_inc >= closed_len) begin
							state_d = `WWDT_ST_OPEN;
							cnt_d   = cnt_zero;
						end
					end
				end
				`WWDT_ST_OPEN: begin
					if (!win_mode) begin
						state_d = `WWDT_ST_NORMAL;
						cnt_d   = cnt_zero;
					end else if (clr_apply) begin
						state_d = `WWDT_ST_CLOSED;
						cnt_d   = cnt_zero;
					end else if (tick) begin
						cnt_d = cnt_inc;
						if (cnt_inc >= open_len) begin
							bite_d  = 1'b1;
							state_d = `WWDT_ST_CLOSED;
							cnt_d   = cnt_zero;
						end
					end
				end
				default: begin
					state_d = `WWDT_ST_OFF;
					cnt_d   = cnt_zero;
				end
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (reset) begin
			state_q         <= `WWDT_ST_OFF;
			cnt_q           <= {(`WWDT_CNT_W+1){1'b0}};
			halted_q        <= 1'b0;
			sys_reset_req_q <= 1'b0;
		end else begin
			state_q         <= state_d;
			cnt_q           <= cnt_d;
			halted_q        <= cpu_halted;
			sys_reset_req_q <= bite_d;
		end
	end

endmodule // wwdt_top

/* File: test/wwdt_chk_sva.sv */
// assertions on the window watchdog timer ports
`timescale 1ns/1ps
module wwdt_chk (
	input wire       core_clk,                // clock
	input wire       reset,                   // sync reset
	input wire [7:0] reg_addr,                // address
	input wire [7:0] reg_wdata,               // write data
	input wire       reg_wr,                  // write strobe
	input wire       reg_rd,                  // read strobe
	input wire [7:0] reg_rdata_q,             // read data
	input wire       timed_unlock_protection, // unlock open
	input wire       cpu_debug_mode,          // debug
	input wire       cpu_halted,              // halted
	input wire [7:0] watchdog_boot_fuse,      // fuse image
	input wire       sys_reset_req_q          // reset request
);
	// ==========================================
	// port properties
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	boot_status_a: assert property ($fell(reset) ##1 (reg_rd && reg_addr == 8'h01) |=>
		reg_rdata_q == {watchdog_boot_fuse[3:0] != 4'h0, 6'h00, 1'b1}) else $error("status after boot wrong");
	pulse_short_a: assert property (sys_reset_req_q |=> !sys_reset_req_q) else $error("reset pulse too long");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 8'h00) else $error("read data without read");
	unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h01 |=> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	status_rsvd_a: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata_q[6:1] == 6'h00)
		else $error("status reserved bits set");
	halt_quiet_a: assert property (cpu_halted [*3] |-> !sys_reset_req_q) else $error("reset while halted");
	lock_set_a: assert property ((reg_wr && reg_addr == 8'h01 && reg_wdata[7] && timed_unlock_protection) ##1
		(reg_rd && reg_addr == 8'h01) |=> reg_rdata_q[7]) else $error("lock not set");
	lock_hold_a: assert property ((reg_rd && reg_addr == 8'h01) ##1
		(reg_rdata_q[7] && reg_wr && reg_addr == 8'h01 && !cpu_debug_mode) ##1 (reg_rd && reg_addr == 8'h01)
		|=> reg_rdata_q[7]) else $error("lock cleared outside debug");
	cover property (sys_reset_req_q);
	cover property (cpu_halted ##1 !cpu_halted);
	cover property (reg_rd && reg_addr == 8'h00);
endmodule // wwdt_chk

bind wwdt_top wwdt_chk u_wwdt_chk (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.timed_unlock_protection(timed_unlock_protection), .cpu_debug_mode(cpu_debug_mode),
	.cpu_halted(cpu_halted), .watchdog_boot_fuse(watchdog_boot_fuse), .sys_reset_req_q(sys_reset_req_q));

/* File: test/wwdt_cpu_model.sv */
// processor core model: turns a bench request into one clear instruction
`timescale 1ns/1ps
module wwdt_cpu_model (
	input  wire core_clk,                  // system clock
	input  wire kick,                      // bench asks for a clear
	output reg  watchdog_clear_instruction // one-cycle clear
);
	initial watchdog_clear_instruction = 1'b0;
	always @(posedge core_clk) begin
		watchdog_clear_instruction <= kick && !watchdog_clear_instruction;
	end
endmodule // wwdt_cpu_model

/* File: test/testbench.sv */
// self-checking bench for the window watchdog timer
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module testbench;
	reg        core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, unlock = 0, dbg = 0, halt = 0, wclk = 0, kick = 0;
	reg  [7:0] reg_addr = 0, reg_wdata = 0, fuse = 0;
	wire [7:0] rdata;
	wire       clr, rst_req;
	reg        rd_seen = 0, b;
	reg  [8:0] expq[$];
	reg  [8:0] ex;
	integer    fail_count = 0, tests_run = 0, pulses = 0, seed = 79217, i, n, m;
	always #25 core_clk = ~core_clk;
	always #200 wclk = ~wclk;
	wwdt_cpu_model u_wwdt_cpu_model (.core_clk(core_clk), .kick(kick), .watchdog_clear_instruction(clr));
	wwdt_top u_wwdt_top (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .watchdog_clear_instruction(clr),
		.timed_unlock_protection(unlock), .cpu_debug_mode(dbg), .cpu_halted(halt),
		.watchdog_boot_fuse(fuse), .watchdog_counter_clock(wclk), .sys_reset_req_q(rst_req));
	// ==========================================
	// result watcher
	always @(posedge core_clk) begin
		rd_seen <= reg_rd;
		if (rst_req === 1'b1) pulses <= pulses + 1;
		if (rd_seen) begin
			ex = expq.pop_front();
			if (ex[8]) `CHK(rdata, ex[7:0])
		end
	end
	// ==========================================
	// drivers
	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, fail_count);
			if (fail_count == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task hang;
		begin
			fail_count++;
			$display("mismatch at %0t: wait timed out", $time);
			give_verdict;
		end
	endtask
	task boot;
		begin
			reset <= 1;
			repeat (4) @(posedge core_clk);
			reset <= 0;
			@(posedge core_clk);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d, input u);
		begin
			reg_wr <= 1;
			reg_addr <= a;
			reg_wdata <= d;
			unlock <= u;
			@(posedge core_clk);
			reg_wr <= 0;
			unlock <= 0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e, input c);
		begin
			expq.push_back({c, e});
			reg_rd <= 1;
			reg_addr <= a;
			@(posedge core_clk);
			reg_rd <= 0;
		end
	endtask
	// polls busy so no control write lands mid-crossing
	task idle;
		begin
			n = 0;
			do begin
				@(posedge core_clk);
				rd(8'h01, 8'h00, 0);
				#10;
				b = rdata[0];
				n++;
			end while (b !== 1'b0 && n < 100);
			@(posedge core_clk);
			if (n >= 100) hang;
		end
	endtask
	// cycles to the next reset pulse, ends on a clock edge
	task till(output integer c);
		begin
			c = 0;
			do begin
				@(posedge core_clk);
				#1;
				c++;
			end while (rst_req !== 1'b1 && c < 5000);
			@(posedge core_clk);
			if (c >= 5000) hang;
		end
	endtask
	task kick_once;
		begin
			kick <= 1;
			@(posedge core_clk);
			kick <= 0;
		end
	endtask
	// ==========================================
	// scenarios
	initial begin
		boot;
		rd(8'h01, 8'h01, 1);
		idle;
		rd(8'h00, 8'h00, 1);
		wr(8'h00, 8'h01, 0);
		rd(8'h00, 8'h00, 1);
		m = pulses;
		repeat (300) @(posedge core_clk);
		`CHK(pulses, m)
		for (i = 1; i < 5; i++) begin
			wr(8'h00, i[7:0], 1);
			idle;
			rd(8'h00, i[7:0], 1);
			till(n);
			till(n);
			`CHK(n + 1, 8 << (i + 2))
		end
		till(n);
		kick_once;
		repeat (4) @(posedge core_clk);
		m = pulses;
		repeat (10) begin
			repeat (40 + $unsigned($random(seed)) % 30) @(posedge core_clk);
			kick_once;
		end
		repeat (40) @(posedge core_clk);
		`CHK(pulses, m)
		wr(8'h00, 8'h14, 1);
		idle;
		kick_once;
		m = pulses;
		repeat (200) @(posedge core_clk);
		`CHK(pulses, m)
		till(n);
		till(n);
		`CHK(n + 1, (8 << 3) + (8 << 6))
		kick_once;
		till(n);
		`CHK(n < 40, 1'b1)
		dbg <= 1;
		halt <= 1;
		repeat (300) @(posedge core_clk);
		halt <= 0;
		dbg <= 0;
		till(n);
		`CHK(n > 500 && n < 530, 1'b1)
		wr(8'h01, 8'h80, 1);
		rd(8'h01, 8'h80, 1);
		wr(8'h00, 8'h00, 1);
		rd(8'h00, 8'h14, 1);
		@(posedge core_clk);
		rd(8'h01, 8'h80, 1);
		wr(8'h01, 8'h00, 1);
		rd(8'h01, 8'h80, 1);
		dbg <= 1;
		wr(8'h01, 8'h00, 1);
		rd(8'h05, 8'h00, 1);
		@(posedge core_clk);
		rd(8'h01, 8'h00, 1);
		dbg <= 0;
		fuse <= 8'h11 + $unsigned($random(seed)) % 11;
		boot;
		rd(8'h01, 8'h81, 1);
		idle;
		rd(8'h00, fuse, 1);
		@(posedge core_clk);
		give_verdict;
	end
endmodule // testbench
